// ==== src/fos_otp_param.sv ====
// Security-mode control and parameter-table read for a serial flash.
// Assumes the host stops the serial clock while select is high.
`timescale 1ns/10ps
module fos_otp_param
	import fos_pkg::*;
(
	// Clocks and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic sclk_in,
	// Serial link
	input wire logic cs_n_in,
	input wire logic si_in,
	output logic so_out,
	output logic so_oe_out,
	// Status sources
	input wire logic wip_in,
	input wire logic wel_in,
	input wire logic [7:0] normal_status_in,
	input wire logic write_ignore_disable_in,
	input wire logic reset_pin_select_in,
	input wire logic [2:0] otp_bits_init_in,
	// Array command hand-off
	output logic [23:0] cand_addr_out,
	input wire logic addr_protected_in,
	output logic cmd_valid_out,
	output logic [7:0] cmd_op_out,
	output logic [23:0] cmd_addr_out,
	output logic cmd_otp_sector_out,
	// Mode and sticky bits
	output logic otp_mode_out,
	output logic otp_lock_out,
	output logic block_sector_switch_out,
	output logic top_bottom_select_out
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	fos_ref_t r_q;
	fos_ref_t r_d;
	fos_link_t l_q;
	fos_link_t l_d;
	fos_cap_t c_q;
	fos_cap_t c_d;
	logic frame_rst;
	logic cs_s2;
	logic cs_s3;
	logic deselect;
	logic [8:0] lk_sync;
	logic lk_wip;
	logic [7:0] lk_status;
	logic [5:0] nb;
	logic [31:0] new_sh;
	logic addr_cmd;
	logic otp_tgt;
	logic issue;
	logic so_q;
	logic oe_q;

	// ------------------------------------------------------------
	// Crossings
	// ------------------------------------------------------------
	// Select pin into the reference domain; a change counts once stages agree
	fos_sync #(
		.W(1),
		.STAGES(3),
		.RST_VAL(1'b1)
	) u_cs_sync (
		.clk_in(ref_clk_in),
		.rst_in(rst_in),
		.d_in(cs_n_in),
		.q_out(cs_s3),
		.prev_out(cs_s2)
	);

	// Status levels into the link domain; they only change between frames,
	// so the opcode's eight edges settle them before they are shifted out
	// Three stages, as for the select pin into the reference domain
	fos_sync #(
		.W(9),
		.STAGES(3),
		.RST_VAL(9'h000)
	) u_stat_sync (
		.clk_in(sclk_in),
		.rst_in(rst_in),
		.d_in({r_q.write_in_progress, r_q.status}),
		.q_out(lk_sync),
		.prev_out()
	);

	assign lk_wip = lk_sync[8];
	assign lk_status = lk_sync[7:0];

	// ------------------------------------------------------------
	// Reference domain
	// ------------------------------------------------------------
	assign deselect = cs_s2 & cs_s3 & ~r_q.cs_hi;
	// Only commands that carry an address may target the sector window; others keep a stale one
	assign addr_cmd = (r_q.op == OP_SECTOR_ERASE_4K) || (r_q.op == OP_PAGE_PROGRAM);
	assign otp_tgt = r_q.mode & addr_cmd & in_otp_window(r_q.addr);

	always_comb begin
		r_d = r_q;
		issue = 1'b0;
		r_d.cmd_valid = 1'b0;
		r_d.write_in_progress = wip_in;
		if (cs_s2 & cs_s3) begin
			r_d.cs_hi = 1'b1;
		end else if (~cs_s2 & ~cs_s3) begin
			r_d.cs_hi = 1'b0;
		end
		// Sticky bits are nonvolatile outside; restore them after reset release
		if (!r_q.loaded) begin
			r_d.sticky = otp_bits_init_in;
			r_d.loaded = 1'b1;
		end
		if (r_q.mode) begin
			r_d.status = 8'h00;
			r_d.status[ST_LOCK] = r_q.sticky[2];
			r_d.status[ST_WRITE_IGNORE_DISABLE] = write_ignore_disable_in;
			r_d.status[ST_RESET_PIN_SELECT] = reset_pin_select_in;
			r_d.status[ST_BS] = r_q.sticky[1];
			r_d.status[ST_TB] = r_q.sticky[0];
			r_d.status[ST_WEL] = wel_in;
			r_d.status[ST_WIP] = wip_in;
		end else begin
			r_d.status = normal_status_in;
		end
		unique case (r_q.st)
			R_IDLE: begin
				// Link capture is frozen: the serial clock is stopped once select is high
				if (deselect) begin
					r_d.op = c_q.op;
					r_d.addr = c_q.addr;
					r_d.data = c_q.data;
					r_d.nbits = c_q.nbits;
					r_d.st = R_CHECK;
				end
			end
			R_CHECK: begin
				r_d.st = R_IDLE;
				if (r_q.nbits == BITS_OPCODE && r_q.op == OP_ENTER_OTP) begin
					r_d.mode = 1'b1;
				end else if (r_q.nbits == BITS_OPCODE && r_q.op == OP_WRITE_DISABLE) begin
					r_d.mode = 1'b0;
					// Forwarded as well, so the array side drops its write latch
					issue = 1'b1;
				end else if (r_q.nbits == BITS_OPCODE &&
					(r_q.op == OP_CHIP_ERASE_A || r_q.op == OP_CHIP_ERASE_B)) begin
					issue = ~r_q.mode;
				end else if (r_q.nbits == BITS_ADDR_END &&
					(r_q.op == OP_BLOCK_ERASE_64K || r_q.op == OP_BLOCK_ERASE_32K)) begin
					issue = ~r_q.mode;
				end else if ((r_q.nbits == BITS_ADDR_END && r_q.op == OP_SECTOR_ERASE_4K) ||
					(r_q.nbits >= BITS_DUMMY_END && r_q.op == OP_PAGE_PROGRAM)) begin
					if (otp_tgt) begin
						issue = ~r_q.sticky[2];
					end else begin
						issue = ~(r_q.mode & addr_protected_in);
					end
				end else if (r_q.nbits == BITS_STATUS_WR && r_q.op == OP_WRITE_STATUS) begin
					if (r_q.mode) begin
						if (wel_in && !wip_in) begin
							// Bits only ever OR in, so no later write can return one to zero
							r_d.sticky = r_q.sticky | {r_q.data[ST_LOCK], r_q.data[ST_BS], r_q.data[ST_TB]};
						end
					end else begin
						issue = 1'b1;
					end
				end
				if (issue) begin
					r_d.cmd_valid = 1'b1;
					r_d.cmd_op = r_q.op;
					r_d.cmd_addr = r_q.addr;
					r_d.cmd_otp = otp_tgt;
				end
			end
			default: r_d.st = R_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			r_q <= REF_RST;
		end else begin
			r_q <= r_d;
		end
	end

	// ------------------------------------------------------------
	// Link domain
	// ------------------------------------------------------------
	// Deselect ends the frame asynchronously; no edge is expected after it
	assign frame_rst = rst_in | cs_n_in;

	always_comb begin
		l_d = l_q;
		c_d = c_q;
		new_sh = {c_q.sh[30:0], si_in};
		if (!l_q.active) begin
			nb = 6'h01;
		end else if (c_q.nbits == BITS_SAT) begin
			nb = BITS_SAT;
		end else begin
			nb = c_q.nbits + 6'h01;
		end
		l_d.active = 1'b1;
		c_d.nbits = nb;
		c_d.sh = new_sh;
		if (nb == BITS_OPCODE) begin
			c_d.op = new_sh[7:0];
		end
		if (nb == BITS_STATUS_WR) begin
			c_d.data = new_sh[7:0];
		end
		if (nb == BITS_ADDR_END) begin
			c_d.addr = new_sh[23:0];
		end
		unique case (l_q.st)
			L_OP: begin
				if (nb == BITS_OPCODE) begin
					if (new_sh[7:0] == OP_PARAM_READ) begin
						l_d.st = lk_wip ? L_SKIP : L_ADDR;
					end else if (new_sh[7:0] == OP_READ_STATUS) begin
						l_d.tx = lk_status;
						l_d.idx = BIT_IDX_FIRST;
						l_d.drive = 1'b1;
						l_d.st = L_STAT;
					end else begin
						l_d.st = L_SKIP;
					end
				end
			end
			L_ADDR: begin
				if (nb == BITS_ADDR_END) begin
					l_d.paddr = new_sh[PARAM_AW-1:0];
					l_d.st = L_DUMMY;
				end
			end
			L_DUMMY: begin
				if (nb == BITS_DUMMY_END) begin
					// Fetched on the last dummy edge, ready for the next falling edge
					l_d.tx = param_byte(l_q.paddr);
					l_d.paddr = l_q.paddr + 1'b1;
					l_d.idx = BIT_IDX_FIRST;
					l_d.drive = 1'b1;
					l_d.st = L_PARAM;
				end
			end
			L_PARAM: begin
				if (l_q.idx == 3'h0) begin
					l_d.tx = param_byte(l_q.paddr);
					// Natural wrap of the counter gives the roll-over to zero
					l_d.paddr = l_q.paddr + 1'b1;
					l_d.idx = BIT_IDX_FIRST;
				end else begin
					l_d.idx = l_q.idx - 3'h1;
				end
			end
			L_STAT: begin
				if (l_q.idx == 3'h0) begin
					l_d.tx = lk_status;
					l_d.idx = BIT_IDX_FIRST;
				end else begin
					l_d.idx = l_q.idx - 3'h1;
				end
			end
			L_SKIP: begin
				// Refused or unsupported frames keep the output released until deselect
				l_d.drive = 1'b0;
			end
			default: l_d.st = L_SKIP;
		endcase
	end

	always_ff @(posedge sclk_in or posedge frame_rst) begin
		if (frame_rst) begin
			l_q <= LINK_RST;
		end else begin
			l_q <= l_d;
		end
	end

	always_ff @(posedge sclk_in or posedge rst_in) begin
		if (rst_in) begin
			c_q <= CAP_RST;
		end else begin
			c_q <= c_d;
		end
	end

	// Output bit launched on the falling edge, half a cycle ahead of host sampling
	always_ff @(negedge sclk_in or posedge frame_rst) begin
		if (frame_rst) begin
			so_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			so_q <= l_q.tx[l_q.idx];
			oe_q <= l_q.drive;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign so_out = so_q;
	assign so_oe_out = oe_q;
	// Lets the outside look up protection in the same cycle that the check uses it
	assign cand_addr_out = r_q.addr;
	assign cmd_valid_out = r_q.cmd_valid;
	assign cmd_op_out = r_q.cmd_op;
	assign cmd_addr_out = r_q.cmd_addr;
	assign cmd_otp_sector_out = r_q.cmd_otp;
	assign otp_mode_out = r_q.mode;
	assign otp_lock_out = r_q.sticky[2];
	assign block_sector_switch_out = r_q.sticky[1];
	assign top_bottom_select_out = r_q.sticky[0];

endmodule : fos_otp_param

// ==== src/fos_pkg.sv ====
// Constants, types and the discoverable-parameter table for the
// security-mode and parameter-read command logic.
// Assumes a single-bit serial link of 8-bit opcodes, 24-bit addresses.
package fos_pkg;

	// ------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_ENTER_OTP = 8'h3a;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OP_PARAM_READ = 8'h5a;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
	localparam logic [7:0] OP_BLOCK_ERASE_64K = 8'hd8;
	localparam logic [7:0] OP_BLOCK_ERASE_32K = 8'h52;
	localparam logic [7:0] OP_SECTOR_ERASE_4K = 8'h20;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;

	// ------------------------------------------------------------
	// Status bit positions in security mode
	// ------------------------------------------------------------
	localparam int ST_LOCK = 7;
	localparam int ST_WRITE_IGNORE_DISABLE = 6;
	localparam int ST_RESET_PIN_SELECT = 5;
	localparam int ST_BS = 4;
	localparam int ST_TB = 3;
	localparam int ST_WEL = 1;
	localparam int ST_WIP = 0;

	// ------------------------------------------------------------
	// Security sector window and frame bit counts
	// ------------------------------------------------------------
	localparam logic [23:0] OTP_BASE = 24'h7ff000;
	localparam logic [23:0] OTP_LAST = 24'h7ff1ff;
	localparam logic [5:0] BITS_OPCODE = 6'h08;
	localparam logic [5:0] BITS_STATUS_WR = 6'h10;
	localparam logic [5:0] BITS_ADDR_END = 6'h20;
	localparam logic [5:0] BITS_DUMMY_END = 6'h28;
	localparam logic [5:0] BITS_SAT = 6'h3f;
	localparam logic [2:0] BIT_IDX_FIRST = 3'h7;
	localparam int PARAM_AW = 8;

	// ------------------------------------------------------------
	// State types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		R_IDLE = 2'b01,
		R_CHECK = 2'b10
	} fos_rstate_t;

	typedef enum logic [5:0] {
		L_OP = 6'b000001,
		L_ADDR = 6'b000010,
		L_DUMMY = 6'b000100,
		L_PARAM = 6'b001000,
		L_STAT = 6'b010000,
		L_SKIP = 6'b100000
	} fos_lstate_t;

	// Reference-clock side: mode, sticky bits, command hand-off
	typedef struct packed {
		fos_rstate_t st;
		logic cs_hi;
		logic loaded;
		logic mode;
		logic [2:0] sticky;
		logic write_in_progress;
		logic [7:0] status;
		logic [7:0] op;
		logic [23:0] addr;
		logic [7:0] data;
		logic [5:0] nbits;
		logic cmd_valid;
		logic [7:0] cmd_op;
		logic [23:0] cmd_addr;
		logic cmd_otp;
	} fos_ref_t;

	// Link side, cleared by every deselect
	typedef struct packed {
		fos_lstate_t st;
		logic active;
		logic drive;
		logic [2:0] idx;
		logic [7:0] tx;
		logic [PARAM_AW-1:0] paddr;
	} fos_link_t;

	// Link side capture, kept across the deselect for the hand-off
	typedef struct packed {
		logic [5:0] nbits;
		logic [31:0] sh;
		logic [7:0] op;
		logic [7:0] data;
		logic [23:0] addr;
	} fos_cap_t;

	localparam logic MODE_RST = 1'b0;
	localparam fos_ref_t REF_RST = '{st: R_IDLE, cs_hi: 1'b1, mode: MODE_RST, default: '0};
	localparam fos_link_t LINK_RST = '{st: L_OP, default: '0};
	localparam fos_cap_t CAP_RST = '{default: '0};

	// ------------------------------------------------------------
	// Parameter table contents; unlisted bytes read as ff
	// ------------------------------------------------------------
	function automatic logic [7:0] param_byte(input logic [PARAM_AW-1:0] a);
		logic [7:0] b;
		b = 8'hff;
		case (a)
			8'h00: b = 8'h53;
			8'h01: b = 8'h46;
			8'h02: b = 8'h44;
			8'h03: b = 8'h50;
			8'h04: b = 8'h00;
			8'h05: b = 8'h01;
			8'h06: b = 8'h00;
			8'h08: b = 8'h00;
			8'h09: b = 8'h00;
			8'h0a: b = 8'h01;
			8'h0b: b = 8'h09;
			8'h0c: b = 8'h30;
			8'h0d: b = 8'h00;
			8'h0e: b = 8'h00;
			8'h30: b = 8'hed;
			8'h31: b = 8'h20;
			8'h32: b = 8'hf1;
			8'h33: b = 8'hff;
			default: b = 8'hff;
		endcase
		return b;
	endfunction : param_byte

	function automatic logic in_otp_window(input logic [23:0] a);
		return (a >= OTP_BASE) && (a <= OTP_LAST);
	endfunction : in_otp_window

endpackage : fos_pkg

// ==== src/fos_sync.sv ====
// Multi-stage level synchroniser with a constant reset value.
// Assumes the input is a level that stays put for several clocks.
`timescale 1ns/10ps
module fos_sync #(
	parameter int W = 1,
	parameter int STAGES = 3,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Data
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out,
	output logic [W-1:0] prev_out
);

	logic [STAGES-1:0][W-1:0] st_q;
	logic [STAGES-1:0][W-1:0] st_d;

	always_comb begin
		st_d = {st_q[STAGES-2:0], d_in};
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= {STAGES{RST_VAL}};
		end else begin
			st_q <= st_d;
		end
	end

	// Only meaningful for three or more stages; the first stage is never exposed then
	assign q_out = st_q[STAGES-1];
	assign prev_out = st_q[STAGES-2];

endmodule : fos_sync

// ==== bench/fos_host.sv ====
// Host serial controller model: frames a command, then clocks in reply bits.
// Assumes mode 0 timing; the clock stands low whenever select is high.
`timescale 1ns/10ps
module fos_host (
	// Link to the device
	output logic sclk_out,
	output logic cs_n_out,
	output logic si_out,
	input wire logic so_in,
	input wire logic so_oe_in
);
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
	end

	// Command bits sit left aligned in tx; idle input toggles so stale data cannot pass
	task automatic xfer(input logic [39:0] tx, input int ntx, input int nrx, output logic [31:0] rx,
		output logic oe);
		rx = '0;
		oe = 1'b0;
		#7 cs_n_out = 1'b0;
		for (int i = 0; i < ntx + nrx; i++) begin
			si_out = (i < ntx) ? tx[39 - i] : ~si_out;
			#16 sclk_out = 1'b1;
			if (i >= ntx) begin
				// A released line reads as the inverse of its level, so late or missing drive shows
				rx = {rx[30:0], so_oe_in ? so_in : ~so_in};
				oe = oe | so_oe_in;
			end
			#16 sclk_out = 1'b0;
		end
		#9 cs_n_out = 1'b1;
		si_out = ~si_out;
	endtask : xfer
endmodule : fos_host

// ==== bench/fos_otp_param_chk.sv ====
// Concurrent checks on the command hand-off, mode flag and output enable.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/10ps
module fos_otp_param_chk
	import fos_pkg::*;
(
	// Clock, reset and link
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic cs_n_in,
	input wire logic so_oe_out,
	// Hand-off and mode
	input wire logic cmd_valid_out,
	input wire logic [7:0] cmd_op_out,
	input wire logic [23:0] cmd_addr_out,
	input wire logic cmd_otp_sector_out,
	input wire logic otp_mode_out,
	input wire logic otp_lock_out,
	input wire logic block_sector_switch_out,
	input wire logic top_bottom_select_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	logic big_erase;
	assign big_erase = cmd_op_out inside {OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_BLOCK_ERASE_64K, OP_BLOCK_ERASE_32K};

	sequence s_issue;
		cmd_valid_out;
	endsequence
	sequence s_exit;
		cmd_valid_out && cmd_op_out == OP_WRITE_DISABLE;
	endsequence

	AST_OE_DESEL: assert property (cs_n_in |-> !so_oe_out)
		else $error("output enabled while deselected");
	AST_ISSUE_DESEL: assert property (s_issue |-> cs_n_in && $past(cs_n_in, 4))
		else $error("command issued inside a frame");
	AST_NO_BIG_ERASE: assert property (s_issue and otp_mode_out |-> !big_erase)
		else $error("large erase forwarded in security mode");
	AST_OTP_ERASE: assert property (s_issue and cmd_otp_sector_out |-> !big_erase)
		else $error("security sector erased by large erase");
	AST_WINDOW: assert property (s_issue and cmd_otp_sector_out |->
		otp_mode_out && cmd_addr_out >= OTP_BASE && cmd_addr_out <= OTP_LAST)
		else $error("security sector flag outside window or mode");
	AST_LOCKED: assert property (s_issue and cmd_otp_sector_out |-> !otp_lock_out)
		else $error("locked security sector accessed");
	AST_STICKY: assert property (!$fell(otp_lock_out) && !$fell(block_sector_switch_out)
		&& !$fell(top_bottom_select_out))
		else $error("sticky bit cleared");
	AST_EXIT: assert property ($fell(otp_mode_out) |-> ##[0:1] s_exit)
		else $error("security mode left without write disable");
	AST_ENTER: assert property ($rose(otp_mode_out) |-> cs_n_in && !cmd_valid_out)
		else $error("security mode entry misplaced");
endmodule : fos_otp_param_chk

bind fos_otp_param fos_otp_param_chk chk_u (.ref_clk_in, .rst_in, .cs_n_in, .so_oe_out, .cmd_valid_out,
	.cmd_op_out, .cmd_addr_out, .cmd_otp_sector_out, .otp_mode_out, .otp_lock_out, .block_sector_switch_out,
	.top_bottom_select_out);

// ==== bench/fos_otp_param_tb.sv ====
// Self-checking bench for the security-mode and parameter-read logic.
// Assumes the host model drives the link and the checker is bound.
`timescale 1ns/10ps
module fos_otp_param_tb
	import fos_pkg::*;
	;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic sclk, cs_n, si, so, so_oe, write_in_progress, write_enable_latch, prot, wxd, rps, cmd_valid, cmd_otp, mode, lock, bss, tbs, oe;
	logic [7:0] nstat, cmd_op;
	logic [2:0] init;
	logic [23:0] cmd_addr, cand;
	logic [31:0] rx;
	int err_count = 0;
	int check_count = 0;
	int pulses = 0;
	int p0;
	logic [7:0] tbl [16] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, 8'hff,
		8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff};
	logic [7:0] ers [4] = '{OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_BLOCK_ERASE_64K, OP_BLOCK_ERASE_32K};

	always #4 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) if (cmd_valid === 1'b1) pulses <= pulses + 1;

	fos_host host_u (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si), .so_in(so), .so_oe_in(so_oe));
	fos_otp_param dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
		.si_in(si), .so_out(so), .so_oe_out(so_oe), .wip_in(write_in_progress), .wel_in(write_enable_latch), .normal_status_in(nstat),
		.write_ignore_disable_in(wxd), .reset_pin_select_in(rps), .otp_bits_init_in(init),
		.cand_addr_out(cand), .addr_protected_in(prot), .cmd_valid_out(cmd_valid), .cmd_op_out(cmd_op),
		.cmd_addr_out(cmd_addr), .cmd_otp_sector_out(cmd_otp), .otp_mode_out(mode), .otp_lock_out(lock),
		.block_sector_switch_out(bss), .top_bottom_select_out(tbs));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Select stays high long enough for the hand-off to land before the next frame
	task automatic frame(input logic [39:0] tx, input int ntx, input int nrx);
		p0 = pulses;
		host_u.xfer(tx, ntx, nrx, rx, oe);
		repeat (30) @(negedge ref_clk_in);
	endtask : frame

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (50000) @(posedge ref_clk_in);
		err_count++;
		$display("wrong value at %0t: run timed out", $time);
		final_report();
	end

	initial begin
		write_in_progress = 1'b0;
		write_enable_latch = 1'b1;
		prot = 1'b0;
		wxd = 1'b1;
		rps = 1'b0;
		nstat = 8'h5c;
		init = 3'b000;
		repeat (4) @(negedge ref_clk_in);
		rst_in = 1'b0;
		repeat (6) @(negedge ref_clk_in);
		check(32'(mode), 32'h0);
		$display("test reset done");
		for (int a = 0; a < 16; a += 4) begin
			frame({OP_PARAM_READ, 24'(a), 8'h00}, 40, 32);
			check(rx, {tbl[a], tbl[a + 1], tbl[a + 2], tbl[a + 3]});
		end
		check(32'(oe), 32'h1);
		frame({OP_PARAM_READ, 24'h0000fe, 8'h00}, 40, 24);
		check(rx, 32'h00ffff53);
		frame({OP_PARAM_READ, 24'h000030, 8'h00}, 40, 8);
		check(rx & 32'h7, 32'h5);
		$display("test table done");
		frame({OP_READ_STATUS, 32'h0}, 8, 16);
		check(rx, 32'h5c5c);
		frame({OP_ENTER_OTP, 32'h0}, 8, 0);
		check(32'(mode), 32'h1);
		check(pulses - p0, 32'h0);
		frame({OP_READ_STATUS, 32'h0}, 8, 8);
		check(rx, 32'h42);
		for (int i = 0; i < 4; i++) begin
			frame({ers[i], OTP_BASE, 8'h00}, (i < 2) ? 8 : 32, 0);
			check(pulses - p0, 32'h0);
		end
		frame({OP_SECTOR_ERASE_4K, OTP_BASE, 8'h00}, 32, 0);
		check(pulses - p0, 32'h1);
		check(32'({cmd_otp, cmd_addr}), 32'({1'b1, OTP_BASE}));
		for (int i = 0; i < 2; i++) begin
			prot = (i == 0);
			frame({OP_SECTOR_ERASE_4K, 24'h001000, 8'h00}, 32, 0);
			check(pulses - p0, 32'(i));
		end
		check(32'(cand), 32'h001000);
		$display("test mode commands done");
		frame({OP_WRITE_STATUS, 8'h98, 24'h0}, 16, 0);
		check(32'({lock, bss, tbs}), 32'h7);
		frame({OP_WRITE_STATUS, 8'h00, 24'h0}, 16, 0);
		check(32'({lock, bss, tbs}), 32'h7);
		rps = 1'b1;
		frame({OP_READ_STATUS, 32'h0}, 8, 8);
		check(rx, 32'hfa);
		frame({OP_SECTOR_ERASE_4K, OTP_BASE, 8'h00}, 32, 0);
		check(pulses - p0, 32'h0);
		frame({OP_WRITE_DISABLE, 32'h0}, 8, 0);
		check(32'({mode, cmd_op}), 32'h004);
		check(pulses - p0, 32'h1);
		frame({OP_CHIP_ERASE_A, 32'h0}, 8, 0);
		check(pulses - p0, 32'h1);
		$display("test lock and exit done");
		write_in_progress = 1'b1;
		frame({OP_PARAM_READ, 32'h0}, 40, 8);
		check(32'(oe), 32'h0);
		check(pulses - p0, 32'h0);
		write_in_progress = 1'b0;
		frame({OP_PARAM_READ, 32'h0}, 40, 5);
		check(rx, 32'h0a);
		check(32'(so_oe), 32'h0);
		$display("test busy and abort done");
		frame({OP_ENTER_OTP, 32'h0}, 8, 0);
		init = 3'b101;
		rst_in = 1'b1;
		repeat (4) @(negedge ref_clk_in);
		rst_in = 1'b0;
		repeat (6) @(negedge ref_clk_in);
		check(32'({mode, lock, bss, tbs}), 32'h5);
		$display("test second reset done");
		final_report();
	end
endmodule : fos_otp_param_tb
